//--- fcpm_cfg.svh
// constants of the flash configuration and programming-mode block
// assumes inclusion by bare name from every design file that needs it
`ifndef FCPM_CFG_SVH
`define FCPM_CFG_SVH

// special-function register addresses
`define FCPM_SFR_CFG_ADDR 8'h93
`define FCPM_SFR_CFG_DATA 8'h94

// configuration byte indices
`define FCPM_IDX_HW_MAIN 7'h7F
`define FCPM_IDX_HW_PWR 7'h7E

// erased flash value and configuration defaults
`define FCPM_ERASED_BYTE 8'hFF
`define FCPM_CFG_ADDR_RST 7'h00

// main byte field positions
`define FCPM_MAIN_ACCESS_SEC 7
`define FCPM_MAIN_PROG_LOCK 6
`define FCPM_MAIN_RST_SEC_LOCK 5
`define FCPM_MAIN_BOOTROM_EN 4
`define FCPM_MAIN_WDT_RST_EN 3
`define FCPM_MAIN_DFLASH_HI 2
`define FCPM_MAIN_DFLASH_LO 0

// power and ports byte field positions
`define FCPM_PWR_DIG_LVL_HI 7
`define FCPM_PWR_DIG_LVL_LO 6
`define FCPM_PWR_ANA_LVL_HI 5
`define FCPM_PWR_ANA_LVL_LO 4
`define FCPM_PWR_ANA_BO_DIS 3
`define FCPM_PWR_DIG_BO_DIS 2
`define FCPM_PWR_PORT0_GPIO 1
`define FCPM_PWR_PORT23_GPIO 0

// memory map
`define FCPM_BOOTROM_USER_BASE 16'hF800
`define FCPM_BOOTROM_PROG_TOP 16'h07FF
`define FCPM_RESET_SECTOR_TOP 16'h0FFF

// cycles for the strobe synchronisers to fill after reset release
`define FCPM_SETTLE_CYCLES 3'h3

`endif

//--- fcpm_pkg.sv
// types of the flash configuration and programming-mode block
// assumes nothing of its surroundings
package fcpm_pkg;

  typedef enum logic [1:0] {
    FCPM_MODE_USER     = 2'b00,
    FCPM_MODE_SERIAL   = 2'b01,
    FCPM_MODE_PARALLEL = 2'b10
  } fcpm_mode_e;

  typedef enum logic [1:0] {
    FCPM_LD_SETTLE = 2'b00,
    FCPM_LD_MAIN   = 2'b01,
    FCPM_LD_PWR    = 2'b10,
    FCPM_LD_RUN    = 2'b11
  } fcpm_ld_e;

endpackage : fcpm_pkg

//--- fcpm_cfg_store.sv
// nonvolatile configuration byte store, 128 bytes by default
// assumes one clock; read is combinational, write and erase clocked
`include "fcpm_cfg.svh"
module fcpm_cfg_store import fcpm_pkg::*; #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // clock
  input wire logic i_clk,
  // access
  input wire logic i_wr,
  input wire logic i_erase,
  input wire logic [AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  // delivered erased, survives reset
  logic [7:0] mem [DEPTH] = '{default: `FCPM_ERASED_BYTE};

  always_ff @(posedge i_clk) begin
    if (i_erase) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= `FCPM_ERASED_BYTE;
      end
    end else if (i_wr) begin
      mem[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_addr];

endmodule : fcpm_cfg_store

//--- fcpm_top.sv
// flash configuration loader and programming-mode selector
// assumes strobe pins asynchronous; bus, fetch and flash ports on I_CORE_CLK
`include "fcpm_cfg.svh"
module fcpm_top import fcpm_pkg::*; #(
  parameter int CFG_DEPTH = 128
) (
  // clock and power-on reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // mode strobe pins
  input wire logic I_PROGRAM_STORE_STROBE_N,
  input wire logic I_ADDRESS_LATCH_STROBE,
  // special-function register access
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic I_SFR_WR,
  input wire logic I_SFR_RD,
  output logic [7:0] O_SFR_RDATA,
  output logic O_SFR_HIT,
  output logic O_CFG_WR_REFUSED,
  // mass erase
  input wire logic I_MASS_ERASE,
  output logic O_MASS_ERASE_DONE,
  // instruction fetch decode
  input wire logic [15:0] I_FETCH_ADDR,
  input wire logic I_FETCH_VALID,
  output logic O_BOOTROM_SEL,
  // flash write gate
  input wire logic I_FLASH_WR_REQ,
  input wire logic [15:0] I_FLASH_WR_ADDR,
  input wire logic I_CODE_FROM_FLASH,
  input wire logic I_USER_APPLICATION_MODE,
  output logic O_FLASH_WR_GRANT,
  output logic O_FLASH_WR_DENY,
  output logic O_PROG_FLASH_ACCESS,
  // watchdog
  input wire logic I_WDT_TIMEOUT,
  output logic O_WDT_RESET,
  // mode status
  output logic O_CONFIG_READY,
  output logic O_SERIAL_PROG_MODE,
  output logic O_PARALLEL_PROG_MODE,
  output logic O_USER_MODE,
  // configuration controls
  output logic O_BOOTROM_ENABLED,
  output logic O_WDT_RESET_EN,
  output logic [2:0] O_DFLASH_SIZE_SEL,
  output logic [1:0] O_DIG_BO_LEVEL,
  output logic [1:0] O_ANA_BO_LEVEL,
  output logic O_ANA_BO_EN,
  output logic O_DIG_BO_EN,
  output logic O_PORT0_EXTMEM,
  output logic O_PORT2_EXTMEM,
  output logic O_P36_P37_MEM_STROBES
);

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic fcpm_mode_e decode_mode(input logic strobe_n, input logic ale);
    if (!strobe_n && ale) begin
      decode_mode = FCPM_MODE_SERIAL;
    end else if (strobe_n && !ale) begin
      decode_mode = FCPM_MODE_PARALLEL;
    end else begin
      decode_mode = FCPM_MODE_USER;
    end
  endfunction : decode_mode

  function automatic logic in_reset_sector(input logic [15:0] addr);
    in_reset_sector = (addr <= `FCPM_RESET_SECTOR_TOP);
  endfunction : in_reset_sector

  //////////////////////////////////////////////////////////////////////////////
  // strobe synchronisers

  logic strobe_m, strobe_q, ale_m, ale_q;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      strobe_m <= 1'b1;
      strobe_q <= 1'b1;
      ale_m <= 1'b1;
      ale_q <= 1'b1;
    end else begin
      strobe_m <= I_PROGRAM_STORE_STROBE_N;
      strobe_q <= strobe_m;
      ale_m <= I_ADDRESS_LATCH_STROBE;
      ale_q <= ale_m;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // loader sequence

  fcpm_ld_e ld_state;
  logic [2:0] settle_cnt;
  fcpm_mode_e mode;
  logic run, prog;
  logic access_sec_n, prog_lock, rst_sec_lock;
  logic [6:0] cfg_addr;
  logic [6:0] st_addr;
  logic [7:0] st_rdata;
  logic st_wr, st_erase, data_wr, wr_ok, ctrl_idx;

  assign run = (ld_state == FCPM_LD_RUN);
  assign prog = (mode != FCPM_MODE_USER);

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      ld_state <= FCPM_LD_SETTLE;
      settle_cnt <= 3'h0;
    end else begin
      case (ld_state)
        FCPM_LD_SETTLE: begin
          settle_cnt <= settle_cnt + 3'h1;
          if (settle_cnt == `FCPM_SETTLE_CYCLES) begin
            ld_state <= FCPM_LD_MAIN;
          end
        end
        FCPM_LD_MAIN: ld_state <= FCPM_LD_PWR;
        FCPM_LD_PWR: ld_state <= FCPM_LD_RUN;
        default: ld_state <= FCPM_LD_RUN;
      endcase
    end
  end

  // mode is written once per reset, nowhere else
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      mode <= FCPM_MODE_USER;
      O_SERIAL_PROG_MODE <= 1'b0;
      O_PARALLEL_PROG_MODE <= 1'b0;
      O_USER_MODE <= 1'b0;
      O_CONFIG_READY <= 1'b0;
    end else begin
      if (ld_state == FCPM_LD_MAIN) begin
        mode <= decode_mode(strobe_q, ale_q);
        O_SERIAL_PROG_MODE <= (decode_mode(strobe_q, ale_q) == FCPM_MODE_SERIAL);
        O_PARALLEL_PROG_MODE <= (decode_mode(strobe_q, ale_q) == FCPM_MODE_PARALLEL);
        O_USER_MODE <= (decode_mode(strobe_q, ale_q) == FCPM_MODE_USER);
      end
      O_CONFIG_READY <= (ld_state == FCPM_LD_PWR) || run;
    end
  end

  // control byte shadows, erased defaults until loaded
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      access_sec_n <= 1'b1;
      prog_lock <= 1'b1;
      rst_sec_lock <= 1'b1;
      O_BOOTROM_ENABLED <= 1'b1;
      O_WDT_RESET_EN <= 1'b1;
      O_DFLASH_SIZE_SEL <= 3'h7;
    end else if (ld_state == FCPM_LD_MAIN) begin
      access_sec_n <= st_rdata[`FCPM_MAIN_ACCESS_SEC];
      prog_lock <= st_rdata[`FCPM_MAIN_PROG_LOCK];
      rst_sec_lock <= st_rdata[`FCPM_MAIN_RST_SEC_LOCK];
      O_BOOTROM_ENABLED <= st_rdata[`FCPM_MAIN_BOOTROM_EN];
      O_WDT_RESET_EN <= st_rdata[`FCPM_MAIN_WDT_RST_EN];
      O_DFLASH_SIZE_SEL <= st_rdata[`FCPM_MAIN_DFLASH_HI:`FCPM_MAIN_DFLASH_LO];
    end else if (st_erase) begin
      // erase lifts security at once
      access_sec_n <= 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_DIG_BO_LEVEL <= 2'h3;
      O_ANA_BO_LEVEL <= 2'h3;
      O_ANA_BO_EN <= 1'b0;
      O_DIG_BO_EN <= 1'b0;
      O_PORT0_EXTMEM <= 1'b0;
      O_PORT2_EXTMEM <= 1'b0;
      O_P36_P37_MEM_STROBES <= 1'b0;
    end else if (ld_state == FCPM_LD_PWR) begin
      O_DIG_BO_LEVEL <= st_rdata[`FCPM_PWR_DIG_LVL_HI:`FCPM_PWR_DIG_LVL_LO];
      O_ANA_BO_LEVEL <= st_rdata[`FCPM_PWR_ANA_LVL_HI:`FCPM_PWR_ANA_LVL_LO];
      O_ANA_BO_EN <= !st_rdata[`FCPM_PWR_ANA_BO_DIS];
      O_DIG_BO_EN <= !st_rdata[`FCPM_PWR_DIG_BO_DIS];
      O_PORT0_EXTMEM <= !st_rdata[`FCPM_PWR_PORT0_GPIO];
      O_PORT2_EXTMEM <= !st_rdata[`FCPM_PWR_PORT23_GPIO];
      O_P36_P37_MEM_STROBES <= !(st_rdata[`FCPM_PWR_PORT0_GPIO] && st_rdata[`FCPM_PWR_PORT23_GPIO]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration store and indirect access

  assign st_addr = (ld_state == FCPM_LD_MAIN) ? `FCPM_IDX_HW_MAIN :
                   (ld_state == FCPM_LD_PWR) ? `FCPM_IDX_HW_PWR : cfg_addr;
  assign data_wr = I_SFR_WR && (I_SFR_ADDR == `FCPM_SFR_CFG_DATA);
  assign ctrl_idx = (cfg_addr == `FCPM_IDX_HW_MAIN) || (cfg_addr == `FCPM_IDX_HW_PWR);
  assign wr_ok = run && prog && !(!access_sec_n && ctrl_idx);
  assign st_wr = data_wr && wr_ok;
  assign st_erase = run && prog && I_MASS_ERASE;

  fcpm_cfg_store #(
    .DEPTH(CFG_DEPTH),
    .AW(7)
  ) u_store (
    .i_clk(I_CORE_CLK),
    .i_wr(st_wr),
    .i_erase(st_erase),
    .i_addr(st_addr),
    .i_wdata(I_SFR_WDATA),
    .o_rdata(st_rdata)
  );

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      cfg_addr <= `FCPM_CFG_ADDR_RST;
    end else if (I_SFR_WR && (I_SFR_ADDR == `FCPM_SFR_CFG_ADDR)) begin
      cfg_addr <= I_SFR_WDATA[6:0];
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_SFR_RDATA <= 8'h00;
      O_SFR_HIT <= 1'b0;
    end else begin
      O_SFR_HIT <= (I_SFR_RD || I_SFR_WR) &&
                   ((I_SFR_ADDR == `FCPM_SFR_CFG_ADDR) || (I_SFR_ADDR == `FCPM_SFR_CFG_DATA));
      if (I_SFR_RD && (I_SFR_ADDR == `FCPM_SFR_CFG_ADDR)) begin
        O_SFR_RDATA <= {1'b0, cfg_addr};
      end else if (I_SFR_RD && (I_SFR_ADDR == `FCPM_SFR_CFG_DATA) && run) begin
        O_SFR_RDATA <= st_rdata;
      end else begin
        O_SFR_RDATA <= 8'h00;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CFG_WR_REFUSED <= 1'b0;
      O_MASS_ERASE_DONE <= 1'b0;
    end else begin
      O_CFG_WR_REFUSED <= data_wr && !wr_ok;
      O_MASS_ERASE_DONE <= st_erase;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fetch decode, flash write gate, watchdog

  logic next_grant, next_deny;

  always_comb begin
    next_grant = 1'b0;
    next_deny = 1'b0;
    if (I_FLASH_WR_REQ && !run) begin
      next_deny = 1'b1;
    end else if (I_FLASH_WR_REQ) begin
      if (I_CODE_FROM_FLASH) begin
        next_deny = 1'b1;
      end else if (prog && !access_sec_n && !I_USER_APPLICATION_MODE) begin
        next_deny = 1'b1;
      end else if (prog_lock) begin
        next_deny = 1'b1;
      end else if (rst_sec_lock && in_reset_sector(I_FLASH_WR_ADDR)) begin
        next_deny = 1'b1;
      end else begin
        next_grant = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_FLASH_WR_GRANT <= 1'b0;
      O_FLASH_WR_DENY <= 1'b0;
      O_PROG_FLASH_ACCESS <= 1'b0;
    end else begin
      O_FLASH_WR_GRANT <= next_grant;
      O_FLASH_WR_DENY <= next_deny;
      O_PROG_FLASH_ACCESS <= run && (!prog || access_sec_n || I_USER_APPLICATION_MODE);
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_BOOTROM_SEL <= 1'b0;
    end else if (prog) begin
      O_BOOTROM_SEL <= run && I_FETCH_VALID && (I_FETCH_ADDR <= `FCPM_BOOTROM_PROG_TOP);
    end else begin
      O_BOOTROM_SEL <= run && I_FETCH_VALID && O_BOOTROM_ENABLED &&
                       (I_FETCH_ADDR >= `FCPM_BOOTROM_USER_BASE);
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_WDT_RESET <= 1'b0;
    end else begin
      O_WDT_RESET <= run && I_WDT_TIMEOUT && O_WDT_RESET_EN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_load_serial;
    (ld_state == FCPM_LD_MAIN) && !strobe_q && ale_q;
  endsequence

  sequence s_load_parallel;
    (ld_state == FCPM_LD_MAIN) && strobe_q && !ale_q;
  endsequence

  sequence s_load_user;
    (ld_state == FCPM_LD_MAIN) && strobe_q && ale_q;
  endsequence

  sequence s_user_cfg_write;
    run && O_USER_MODE && data_wr;
  endsequence

  AST_SERIAL_SEL: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_load_serial |=> O_SERIAL_PROG_MODE && !O_USER_MODE ##1 O_CONFIG_READY)
    else $error("serial strobes did not select serial mode");

  AST_PARALLEL_SEL: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_load_parallel |=> O_PARALLEL_PROG_MODE && !O_SERIAL_PROG_MODE)
    else $error("parallel strobes did not select parallel mode");

  AST_USER_SEL: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_load_user |=> O_USER_MODE && !O_PARALLEL_PROG_MODE && !O_SERIAL_PROG_MODE)
    else $error("user strobes did not select user mode");

  AST_MODE_HELD: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_CONFIG_READY |=> $stable(O_SERIAL_PROG_MODE) && $stable(O_PARALLEL_PROG_MODE) && $stable(O_USER_MODE))
    else $error("mode changed without power-on reset");

  AST_LOAD_TIME: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (ld_state == FCPM_LD_SETTLE) |-> ##[1:6] O_CONFIG_READY)
    else $error("configuration load did not finish in time");

  AST_BOOTROM_USER: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run && O_USER_MODE && O_BOOTROM_ENABLED && I_FETCH_VALID && (I_FETCH_ADDR >= 16'hF800) |=> O_BOOTROM_SEL)
    else $error("boot rom not decoded at top of user space");

  AST_BOOTROM_PROG: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    run && !O_USER_MODE && I_FETCH_VALID |=> O_BOOTROM_SEL == ($past(I_FETCH_ADDR) < 16'h0800))
    else $error("boot rom not mapped to lowest 2kB in programming mode");

  AST_NO_FLASH_CODE_WR: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_FLASH_WR_REQ && I_CODE_FROM_FLASH |=> O_FLASH_WR_DENY && !O_FLASH_WR_GRANT)
    else $error("flash write granted to code running from flash");

  AST_USER_CFG_RO: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s_user_cfg_write |-> !st_wr ##1 O_CFG_WR_REFUSED)
    else $error("configuration byte written in user mode");

  AST_SECURE_FREEZE: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    data_wr && !access_sec_n && ctrl_idx |=> O_CFG_WR_REFUSED)
    else $error("secured control byte accepted a write");

  AST_PROG_LOCK: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_FLASH_WR_REQ && prog_lock |=> !O_FLASH_WR_GRANT)
    else $error("flash write granted under program lock");

  AST_WDT_GATE: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_WDT_RESET |-> $past(I_WDT_TIMEOUT) && O_WDT_RESET_EN)
    else $error("watchdog reset without enabled timeout");

endmodule : fcpm_top

//--- fcpm_prog_host.sv
// strap pin driver standing in for the external programmer
// assumes the bench holds the chosen mode through reset and the load
module fcpm_prog_host import fcpm_pkg::*; (
  // requested mode
  input wire fcpm_mode_e i_mode,
  // strap pins
  output logic o_program_store_strobe_n,
  output logic o_address_latch_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // both strobes low is never presented
  always_comb begin
    case (i_mode)
      FCPM_MODE_SERIAL: begin
        o_program_store_strobe_n = 1'b0;
        o_address_latch_strobe = 1'b1;
      end
      FCPM_MODE_PARALLEL: begin
        o_program_store_strobe_n = 1'b1;
        o_address_latch_strobe = 1'b0;
      end
      default: begin
        o_program_store_strobe_n = 1'b1;
        o_address_latch_strobe = 1'b1;
      end
    endcase
  end
endmodule : fcpm_prog_host

//--- fcpm_tb_top.sv
// self-checking bench of the configuration loader and mode selector
// assumes the configuration store keeps its contents across resets
module fcpm_tb_top import fcpm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fcpm_mode_e mode = FCPM_MODE_USER;
  wire strobe_n;
  wire ale;
  logic [7:0] sa = 8'h00;
  logic [7:0] sd = 8'h00;
  logic [15:0] fa = 16'h0000;
  logic [15:0] wa = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, er = 1'b0, fv = 1'b0, fr = 1'b0, cff = 1'b0, app = 1'b0, wdt = 1'b0;
  logic [7:0] rdata;
  logic hit, refd, edone, bsel, gr, dn, pacc, wrst, rdy, ser, par, usr, ben, wen, ae, de, p0, p2, ps;
  logic [2:0] dfs;
  logic [1:0] dl, al;
  int bad_count = 0;
  int check_count = 0;
  // fetch rows in user mode: valid and address, then expected select
  localparam logic [16:0] FROW [5] = '{17'h1F800, 17'h1FFFF, 17'h1F7FF, 17'h0F900, 17'h10000};
  localparam logic FEXP [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  always #2 clk = ~clk;

  fcpm_prog_host fcpm_prog_host_i (.i_mode(mode), .o_program_store_strobe_n(strobe_n),
    .o_address_latch_strobe(ale));

  fcpm_top fcpm_top_i (.I_CORE_CLK(clk), .I_RST(rst), .I_PROGRAM_STORE_STROBE_N(strobe_n),
    .I_ADDRESS_LATCH_STROBE(ale), .I_SFR_ADDR(sa), .I_SFR_WDATA(sd), .I_SFR_WR(wr), .I_SFR_RD(rd),
    .O_SFR_RDATA(rdata), .O_SFR_HIT(hit), .O_CFG_WR_REFUSED(refd), .I_MASS_ERASE(er),
    .O_MASS_ERASE_DONE(edone), .I_FETCH_ADDR(fa), .I_FETCH_VALID(fv), .O_BOOTROM_SEL(bsel),
    .I_FLASH_WR_REQ(fr), .I_FLASH_WR_ADDR(wa), .I_CODE_FROM_FLASH(cff), .I_USER_APPLICATION_MODE(app),
    .O_FLASH_WR_GRANT(gr), .O_FLASH_WR_DENY(dn), .O_PROG_FLASH_ACCESS(pacc), .I_WDT_TIMEOUT(wdt),
    .O_WDT_RESET(wrst), .O_CONFIG_READY(rdy), .O_SERIAL_PROG_MODE(ser), .O_PARALLEL_PROG_MODE(par),
    .O_USER_MODE(usr), .O_BOOTROM_ENABLED(ben), .O_WDT_RESET_EN(wen), .O_DFLASH_SIZE_SEL(dfs),
    .O_DIG_BO_LEVEL(dl), .O_ANA_BO_LEVEL(al), .O_ANA_BO_EN(ae), .O_DIG_BO_EN(de),
    .O_PORT0_EXTMEM(p0), .O_PORT2_EXTMEM(p2), .O_P36_P37_MEM_STROBES(ps));

  ////////////////////////////////////////////////////////////////////////////////
  task summarize;
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // request edge passes, strobes drop, answer settles
  task go;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    er <= 1'b0;
    fv <= 1'b0;
    fr <= 1'b0;
    wdt <= 1'b0;
    #1;
  endtask : go

  task boot(input fcpm_mode_e m);
    @(posedge clk);
    rst <= 1'b1;
    mode <= m;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && rdy !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (rdy !== 1'b1) begin
      bad_count++;
      summarize();
    end
    @(posedge clk);
    #1;
  endtask : boot

  task sw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sa <= a;
    sd <= d;
    wr <= 1'b1;
    go();
  endtask : sw

  task sr(input logic [7:0] a);
    @(posedge clk);
    sa <= a;
    rd <= 1'b1;
    go();
  endtask : sr

  task fl(input logic [15:0] a, input logic c, input logic u);
    @(posedge clk);
    wa <= a;
    cff <= c;
    app <= u;
    fr <= 1'b1;
    go();
  endtask : fl

  task fe(input logic [15:0] a, input logic v);
    @(posedge clk);
    fa <= a;
    fv <= v;
    go();
  endtask : fe

  task pulse_wdt;
    @(posedge clk);
    wdt <= 1'b1;
    go();
  endtask : pulse_wdt

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    chk({ben, wen, dfs, dl, al, usr, rdy}, 16'(11'b1_1_111_11_11_0_0));
    boot(FCPM_MODE_USER);
    chk({usr, ser, par}, 16'h0004);
    for (int i = 0; i < 5; i++) begin
      fe(FROW[i][15:0], FROW[i][16]);
      chk(bsel, FEXP[i]);
    end
    sw(8'h93, 8'h7F);
    chk(hit, 16'h0001);
    sr(8'h94);
    chk(rdata, 16'h00FF);
    sw(8'h94, 8'h00);
    chk(refd, 16'h0001);
    sr(8'h94);
    chk(rdata, 16'h00FF);
    sr(8'h95);
    chk({hit, rdata}, 16'h0000);
    sr(8'h93);
    chk(rdata, 16'h007F);
    fl(16'h2000, 1'b0, 1'b1);
    chk({gr, dn}, 16'h0001);
    pulse_wdt();
    chk(wrst, 16'h0001);
    boot(FCPM_MODE_SERIAL);
    chk({usr, ser, par}, 16'h0002);
    fe(16'h0100, 1'b1);
    chk(bsel, 16'h0001);
    fe(16'hF900, 1'b1);
    chk(bsel, 16'h0000);
    sw(8'h93, 8'h7F);
    sw(8'h94, 8'h87);
    chk(refd, 16'h0000);
    sw(8'h93, 8'h7E);
    sw(8'h94, 8'h50);
    sr(8'h94);
    chk(rdata, 16'h0050);
    sw(8'h93, 8'h7F);
    sr(8'h94);
    chk(rdata, 16'h0087);
    fl(16'h2000, 1'b0, 1'b0);
    chk({gr, dn}, 16'h0001);
    boot(FCPM_MODE_PARALLEL);
    chk({usr, ser, par}, 16'h0001);
    chk({ben, wen, dfs, dl, al}, 16'(9'b0_0_111_01_01));
    chk({ae, de, p0, p2, ps}, 16'h001F);
    fl(16'h2000, 1'b0, 1'b0);
    chk({gr, dn}, 16'h0002);
    fl(16'h0100, 1'b0, 1'b0);
    chk({gr, dn}, 16'h0002);
    fl(16'h2000, 1'b1, 1'b0);
    chk({gr, dn}, 16'h0001);
    chk(pacc, 16'h0001);
    pulse_wdt();
    chk(wrst, 16'h0000);
    sw(8'h93, 8'h7F);
    sw(8'h94, 8'h05);
    boot(FCPM_MODE_USER);
    chk({usr, ser, par}, 16'h0004);
    chk(dfs, 16'h0005);
    fe(16'hF900, 1'b1);
    chk(bsel, 16'h0000);
    boot(FCPM_MODE_SERIAL);
    chk(pacc, 16'h0000);
    fl(16'h2000, 1'b0, 1'b0);
    chk({gr, dn}, 16'h0001);
    fl(16'h2000, 1'b0, 1'b1);
    chk({gr, dn}, 16'h0002);
    sw(8'h93, 8'h7F);
    sw(8'h94, 8'hFF);
    chk(refd, 16'h0001);
    @(posedge clk);
    er <= 1'b1;
    app <= 1'b0;
    go();
    chk({edone, pacc}, 16'h0002);
    sr(8'h94);
    chk({pacc, rdata}, 16'h01FF);
    sw(8'h94, 8'hBF);
    boot(FCPM_MODE_USER);
    fl(16'h0FFF, 1'b0, 1'b0);
    chk({gr, dn}, 16'h0001);
    fl(16'h1000, 1'b0, 1'b0);
    chk({gr, dn}, 16'h0002);
    summarize();
  end
endmodule : fcpm_tb_top
